// >>> stack_frame_pkg.sv
package stack_frame_pkg;
    // ************************************************************
    // instruction layout
    // ************************************************************
    localparam logic [4:0] MAJOR_GROUP_EIGHT = 5'h0c;
    localparam logic [2:0] SAVE_RESTORE_FUNC = 3'h4;
    localparam logic [4:0] PREFIX_WIDE_IMMEDIATE = 5'h1e;
    localparam int MAJOR_LSB = 11;
    localparam int FUNC_LSB = 8;
    localparam int SAVE_BIT = 7;
    localparam int RETURN_LINK_BIT = 6;
    localparam int STATIC_LOW_BIT = 5;
    localparam int STATIC_HIGH_BIT = 4;
    localparam int PREFIX_LSB = 27;
    localparam int XS_LSB = 24;
    localparam int FRAME_HI_LSB = 20;
    localparam int SPLIT_LSB = 16;
    localparam int FRAME_SHIFT = 3;
    localparam logic [10:0] ZERO_FRAME_BYTES = 11'h080;
    localparam logic [2:0] STATIC_THIRTY_LIMIT = 3'h6;
    // ************************************************************
    // registers and sequence steps
    // ************************************************************
    localparam logic [4:0] GPR_SP = 5'h1d;
    localparam logic [4:0] GPR_LINK = 5'h1f;
    localparam logic [4:0] GPR_ARG_BASE = 5'h04;
    localparam logic [4:0] GPR_XS_TOP = 5'h17;
    localparam logic [4:0] GPR_THIRTY = 5'h1e;
    localparam logic [4:0] GPR_STATIC_TOP = 5'h07;
    localparam int NUM_STEPS = 18;
    localparam int STEP_LINK = 4;
    localparam int STEP_XS30 = 5;
    localparam int STEP_XS = 6;
    localparam int STEP_S1 = 12;
    localparam int STEP_S0 = 13;
    localparam int STEP_ST = 14;
    localparam logic [63:0] WORD_BYTES = 64'h4;
    // ************************************************************
    // software view
    // ************************************************************
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] COUNT_OFFSET = 12'h008;
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam int CTRL_BIG_BIT = 0;
    localparam int CTRL_FLIP_BIT = 1;
    localparam int CTRL_EN_BIT = 2;
    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_TLB_REFILL = 3'h1,
        EXC_TLB_INVALID = 3'h2,
        EXC_TLB_MODIFIED = 3'h3,
        EXC_ADDR_ERROR = 3'h4,
        EXC_BUS_ERROR = 3'h5
    } exc_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ISSUE = 4'h2,
        ST_WAIT = 4'h4,
        ST_COMMIT = 4'h8
    } state_type;
endpackage

// >>> arg_split_decode.sv
`timescale 1ns/1ps
`default_nettype none
module arg_split_decode
    import stack_frame_pkg::*;
(
    // split field
    input wire logic [3:0] split,
    // counts
    output logic [2:0] staticCount,
    output logic [2:0] argCount
);
    always_comb
    begin
        unique case (split)
            4'h0, 4'h4, 4'h8, 4'hc, 4'he: staticCount = 3'h0;
            4'h1, 4'h5, 4'h9, 4'hd: staticCount = 3'h1;
            4'h2, 4'h6, 4'ha: staticCount = 3'h2;
            4'h3, 4'h7: staticCount = 3'h3;
            4'hb: staticCount = 3'h4;
            default: staticCount = 3'h0; // reserved code, any result allowed
        endcase
        unique case (split)
            4'h0, 4'h1, 4'h2, 4'h3, 4'hb: argCount = 3'h0;
            4'h4, 4'h5, 4'h6, 4'h7: argCount = 3'h1;
            4'h8, 4'h9, 4'ha: argCount = 3'h2;
            4'hc, 4'hd: argCount = 3'h3;
            4'he: argCount = 3'h4;
            default: argCount = 3'h0;
        endcase
    end
endmodule
`default_nettype wire

// >>> stack_lane_align.sv
`timescale 1ns/1ps
`default_nettype none
module stack_lane_align
(
    // access
    input wire logic [2:0] vaddrLow,
    input wire logic bigEndian,
    // data
    input wire logic [63:0] storeValue,
    input wire logic [63:0] loadDword,
    output logic [63:0] storeDword,
    output logic [63:0] loadWord
);
    logic [2:0] lane;
    logic [31:0] picked;
    assign lane = vaddrLow ^ {bigEndian, 2'b00};
    // only the word lanes 0 and 4 occur once the address is aligned
    assign picked = lane[2] ? loadDword[63:32] : loadDword[31:0];
    assign loadWord = {{32{picked[31]}}, picked};
    // upper half cleared so only the low word of the register ever leaves
    assign storeDword = lane[2] ? {storeValue[31:0], 32'h0} : {32'h0, storeValue[31:0]};
endmodule
`default_nettype wire

// >>> stack_frame_save_restore_seq.sv
// Operation
// - restore top equals sp plus frame times eight
// - restore extra statics downward, thirty first
// - restore high then low static after extras
// - decode static argument count from split field
// - restore statics seven down to four
// - misaligned stack word access raises address error
// - load picks endian lane, sign-extends word
// - exception restarts whole instruction later
// - recognise sixteen-bit save form
// - save link, high, low downward from sp
// - save sp minus frame times eight, zero is 128 in plain form
// - stores write low word in endian lane
// - save misaligned sp with registers faults
// - report translation, alignment and bus faults
// - store carries attribute, flipped paddr, vaddr, data
// - extended form and eight-bit frame decrement
// - arguments ascend from four, statics descend seven
// - decode argument count from split field
// - extended save args upward, then rest downward
// - restore misaligned sp with loads faults
`timescale 1ns/1ps
`default_nettype none
module stack_frame_save_restore_seq
    import stack_frame_pkg::*;
#(
    parameter int PADDR_WIDTH = 36
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded instruction
    input wire logic instrValid,
    input wire logic instrExtended,
    input wire logic [31:0] instrWord,
    output logic instrReady,
    output logic instrDone,
    // register file
    input wire logic [63:0] stackPointer,
    output logic [4:0] gprRdAddr,
    input wire logic [63:0] gprRdData,
    output logic gprWrEn,
    output logic [4:0] gprWrAddr,
    output logic [63:0] gprWrData,
    // address translation
    output logic [63:0] xlatVaddr,
    output logic xlatStore,
    input wire logic [PADDR_WIDTH-1:0] xlatPaddr,
    input wire logic [2:0] xlatCacheAttr,
    input wire logic xlatExc,
    input wire logic [2:0] xlatExcCode,
    // data memory
    output logic memReq,
    output logic memWrite,
    output logic [2:0] memCacheAttr,
    output logic [PADDR_WIDTH-1:0] memPaddr,
    output logic [63:0] memVaddr,
    output logic [63:0] memWdata,
    input wire logic memDone,
    input wire logic memBusError,
    input wire logic [63:0] memRdata,
    // exception
    output logic excValid,
    output logic [2:0] excCode,
    output logic [63:0] excVaddr
);
    initial
    begin
        if (PADDR_WIDTH < 4 || PADDR_WIDTH > 64)
            $error("PADDR_WIDTH out of range");
    end

    // ************************************************************
    // software registers
    // ************************************************************
    logic [2:0] ctrl_q;
    logic [31:0] doneCount_q;
    logic [2:0] lastExc_q;
    logic apbWrite;
    logic apbRead;
    logic apbMapped;
    state_type state_q;

    assign apbMapped = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET || paddr == COUNT_OFFSET;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apbMapped;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl_q <= CTRL_RESET;
        else if (apbWrite && paddr == CTRL_OFFSET)
            ctrl_q <= pwdata[2:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            prdata <= 32'h0;
        else if (apbRead && !penable)
        begin
            if (paddr == CTRL_OFFSET)
                prdata <= {29'h0, ctrl_q};
            else if (paddr == STATUS_OFFSET)
                prdata <= {28'h0, lastExc_q, !state_q[0]};
            else if (paddr == COUNT_OFFSET)
                prdata <= doneCount_q;
            else
                prdata <= 32'h0;
        end
    end

    // ************************************************************
    // decode
    // ************************************************************
    logic [31:0] word;
    logic isOurs;
    logic isSave;
    logic [2:0] xsCount;
    logic [2:0] staticCount;
    logic [2:0] argCount;
    logic [10:0] frameBytes;
    logic [NUM_STEPS-1:0] newMask;
    logic accept;

    // plain form reads its extension fields as zero
    assign word = instrExtended ? instrWord : {16'h0, instrWord[15:0]};
    assign isOurs = word[MAJOR_LSB+:5] == MAJOR_GROUP_EIGHT
        && word[FUNC_LSB+:3] == SAVE_RESTORE_FUNC
        && (!instrExtended || word[PREFIX_LSB+:5] == PREFIX_WIDE_IMMEDIATE);
    assign isSave = word[SAVE_BIT];
    assign xsCount = word[XS_LSB+:3];

    arg_split_decode splitDecode (
        .split(word[SPLIT_LSB+:4]),
        .staticCount(staticCount),
        .argCount(argCount)
    );

    always_comb
    begin
        if (!instrExtended && word[3:0] == 4'h0)
            frameBytes = ZERO_FRAME_BYTES;
        else
            frameBytes = {word[FRAME_HI_LSB+:4], word[3:0], 3'b000};
    end

    always_comb
    begin
        newMask = '0;
        for (int i = 0; i < 4; i++)
        begin
            newMask[i] = isSave && argCount > 3'(i);
            newMask[STEP_ST + i] = staticCount > 3'(i);
        end
        newMask[STEP_LINK] = word[RETURN_LINK_BIT];
        newMask[STEP_XS30] = xsCount > STATIC_THIRTY_LIMIT;
        for (int j = 0; j < 6; j++)
            newMask[STEP_XS + j] = xsCount > 3'(5 - j);
        newMask[STEP_S1] = word[STATIC_HIGH_BIT];
        newMask[STEP_S0] = word[STATIC_LOW_BIT];
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    logic [NUM_STEPS-1:0] mask_q;
    logic save_q;
    logic [63:0] base_q;
    logic [63:0] ptr_q;
    logic [63:0] newSp_q;
    logic [4:0] step;
    logic [4:0] stepReg;
    logic [63:0] curVaddr;
    logic [63:0] storeDword;
    logic [63:0] loadWord;
    logic [2:0] xlatFault;
    logic lastStep;
    logic preFault;

    assign accept = instrValid && instrReady;
    assign instrReady = state_q == ST_IDLE && ctrl_q[CTRL_EN_BIT];
    assign preFault = stackPointer[1:0] != 2'b00 && newMask != '0;

    always_comb
    begin
        step = 5'h0;
        for (int k = NUM_STEPS - 1; k >= 0; k--)
            if (mask_q[k])
                step = 5'(k);
    end

    always_comb
    begin
        if (step < 5'(STEP_LINK))
            stepReg = GPR_ARG_BASE + step;
        else if (step == 5'(STEP_LINK))
            stepReg = GPR_LINK;
        else if (step == 5'(STEP_XS30))
            stepReg = GPR_THIRTY;
        else if (step < 5'(STEP_ST))
            stepReg = GPR_XS_TOP - (step - 5'(STEP_XS)); // s1, s0 land on 17, 16
        else
            stepReg = GPR_STATIC_TOP - (step - 5'(STEP_ST));
    end

    // arguments sit at and above the entry pointer, everything else below ptr_q (sp for save, sp plus frame for restore)
    assign curVaddr = step < 5'(STEP_LINK) ? base_q + {57'h0, step, 2'b00} : ptr_q - WORD_BYTES;
    assign lastStep = (mask_q & (mask_q - 1'b1)) == '0;
    assign gprRdAddr = stepReg;
    assign xlatVaddr = curVaddr;
    assign xlatStore = save_q;
    // loads never see a modified fault
    assign xlatFault = !save_q && xlatExcCode == EXC_TLB_MODIFIED ? EXC_NONE : xlatExcCode;

    stack_lane_align laneAlign (
        .vaddrLow(curVaddr[2:0]),
        .bigEndian(ctrl_q[CTRL_BIG_BIT]),
        .storeValue(gprRdData),
        .loadDword(memRdata),
        .storeDword(storeDword),
        .loadWord(loadWord)
    );

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (accept && isOurs && !preFault)
                        state_q <= newMask == '0 ? ST_COMMIT : ST_ISSUE;
                ST_ISSUE:
                    if (curVaddr[1:0] != 2'b00 || (xlatExc && xlatFault != EXC_NONE))
                        state_q <= ST_IDLE;
                    else
                        state_q <= ST_WAIT;
                ST_WAIT:
                    if (memDone)
                        state_q <= memBusError ? ST_IDLE : (lastStep ? ST_COMMIT : ST_ISSUE);
                ST_COMMIT:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mask_q <= '0;
            save_q <= 1'b0;
            base_q <= 64'h0;
            ptr_q <= 64'h0;
            newSp_q <= 64'h0;
        end
        else if (accept)
        begin
            mask_q <= newMask;
            save_q <= isSave;
            base_q <= stackPointer;
            // restart takes the pointer afresh, so a fault leaves no stale pointer behind
            ptr_q <= isSave ? stackPointer : stackPointer + {53'h0, frameBytes};
            newSp_q <= isSave ? stackPointer - {53'h0, frameBytes}
                : stackPointer + {53'h0, frameBytes};
        end
        else if (state_q == ST_WAIT && memDone && !memBusError)
        begin
            mask_q <= mask_q & (mask_q - 1'b1);
            if (step >= 5'(STEP_LINK))
                ptr_q <= ptr_q - WORD_BYTES;
        end
    end

    // ************************************************************
    // memory request
    // ************************************************************
    logic [4:0] loadReg_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memCacheAttr <= 3'h0;
            memPaddr <= '0;
            memVaddr <= 64'h0;
            memWdata <= 64'h0;
            loadReg_q <= 5'h0;
        end
        else if (state_q == ST_ISSUE && curVaddr[1:0] == 2'b00 && !(xlatExc && xlatFault != EXC_NONE))
        begin
            memReq <= 1'b1;
            memWrite <= save_q;
            memCacheAttr <= xlatCacheAttr;
            memPaddr <= {xlatPaddr[PADDR_WIDTH-1:3],
                xlatPaddr[2:0] ^ {ctrl_q[CTRL_FLIP_BIT], 2'b00}};
            memVaddr <= curVaddr;
            memWdata <= save_q ? storeDword : 64'h0;
            loadReg_q <= stepReg;
        end
        else if (memDone)
            memReq <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gprWrEn <= 1'b0;
            gprWrAddr <= 5'h0;
            gprWrData <= 64'h0;
        end
        else if (state_q == ST_WAIT && memDone && !memBusError && !save_q)
        begin
            gprWrEn <= 1'b1;
            gprWrAddr <= loadReg_q;
            gprWrData <= loadWord;
        end
        else if (state_q == ST_COMMIT)
        begin
            gprWrEn <= 1'b1;
            gprWrAddr <= GPR_SP;
            gprWrData <= newSp_q;
        end
        else
            gprWrEn <= 1'b0;
    end

    // ************************************************************
    // exceptions and completion
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            excValid <= 1'b0;
            excCode <= EXC_NONE;
            excVaddr <= 64'h0;
            lastExc_q <= EXC_NONE;
        end
        else if (accept && isOurs && preFault)
        begin
            excValid <= 1'b1;
            excCode <= EXC_ADDR_ERROR;
            excVaddr <= stackPointer;
            lastExc_q <= EXC_ADDR_ERROR;
        end
        else if (state_q == ST_ISSUE && (curVaddr[1:0] != 2'b00 || (xlatExc && xlatFault != EXC_NONE)))
        begin
            excValid <= 1'b1;
            excCode <= curVaddr[1:0] != 2'b00 ? EXC_ADDR_ERROR : xlatFault;
            excVaddr <= curVaddr;
            lastExc_q <= curVaddr[1:0] != 2'b00 ? EXC_ADDR_ERROR : xlatFault;
        end
        else if (state_q == ST_WAIT && memDone && memBusError)
        begin
            excValid <= 1'b1;
            excCode <= EXC_BUS_ERROR;
            excVaddr <= memVaddr;
            lastExc_q <= EXC_BUS_ERROR;
        end
        else
            excValid <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            instrDone <= 1'b0;
            doneCount_q <= 32'h0;
        end
        else
        begin
            instrDone <= state_q == ST_COMMIT || (accept && !isOurs);
            if (state_q == ST_COMMIT)
                doneCount_q <= doneCount_q + 32'h1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence spWrite;
        gprWrEn && gprWrAddr == GPR_SP;
    endsequence
    sequence faultSeen;
        excValid;
    endsequence

    a_one_outstanding: assert property (memReq && !memDone |=> memReq && $stable(memVaddr))
        else $error("access changed before completion");
    a_aligned_access: assert property (memReq |-> memVaddr[1:0] == 2'b00)
        else $error("misaligned access issued");
    a_fault_no_commit: assert property (faultSeen |-> ##1 !spWrite ##1 !spWrite)
        else $error("stack pointer written after fault");
    a_sp_after_access: assert property (spWrite |-> !memReq && $past(state_q) == ST_COMMIT)
        else $error("stack pointer written mid sequence");
    a_load_sign_ext: assert property (gprWrEn && gprWrAddr != GPR_SP
        |-> gprWrData[63:32] == {32{gprWrData[31]}})
        else $error("load not sign extended");
    a_zero_frame_save: assert property (accept && isOurs && isSave && !instrExtended && word[3:0] == 4'h0
        |=> newSp_q == base_q - 64'h80)
        else $error("zero frame did not subtract 128");
    a_restore_no_mod: assert property (excValid && !save_q |-> excCode != EXC_TLB_MODIFIED)
        else $error("restore reported modified fault");
    a_split_total: assert property (word[SPLIT_LSB+:4] != 4'hf |-> 4'(argCount) + 4'(staticCount) <= 4'h4)
        else $error("split decode overlaps");
    a_store_lane: assert property (memReq && memWrite && (memVaddr[2] ^ ctrl_q[CTRL_BIG_BIT])
        |-> memWdata[31:0] == 32'h0)
        else $error("store lane wrong");
    a_store_low_word: assert property (memReq && memWrite && !(memVaddr[2] ^ ctrl_q[CTRL_BIG_BIT])
        |-> memWdata[63:32] == 32'h0)
        else $error("store leaked upper word");
endmodule
`default_nettype wire

// >>> mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mem_partner
    import stack_frame_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // scenario control
    input wire logic [3:0] latency,
    input wire logic [4:0] faultAt,
    // translation
    input wire logic [63:0] xlatVaddr,
    output logic [35:0] xlatPaddr,
    output logic [2:0] xlatCacheAttr,
    output logic xlatExc,
    output logic [2:0] xlatExcCode,
    // memory
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [63:0] memVaddr,
    input wire logic [63:0] memWdata,
    output logic memDone,
    output logic memBusError,
    output logic [63:0] memRdata
);
    logic [3:0] waitCnt;
    logic [4:0] nAcc;
    logic [63:0] logAddr [0:31];
    logic [63:0] logData [0:31];
    logic logWrite [0:31];
    assign xlatPaddr = xlatVaddr[35:0];
    assign xlatCacheAttr = 3'h3;
    assign xlatExc = (nAcc == faultAt);
    assign xlatExcCode = EXC_TLB_INVALID;
    assign memBusError = 1'b0;
    // outside the done cycle the bus shows other bits, so stale data never matches
    assign memRdata = memDone ? 64'h8765_4321_1234_5678 : 64'h789a_bcde_edcb_a987;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            waitCnt <= 4'h0;
            nAcc <= 5'h0;
            memDone <= 1'b0;
        end
        else if (memReq && !memDone && waitCnt == latency)
        begin
            memDone <= 1'b1;
            waitCnt <= 4'h0;
        end
        else
        begin
            memDone <= 1'b0;
            waitCnt <= (memReq && !memDone) ? waitCnt + 4'h1 : 4'h0;
        end
        if (rst_n && memReq && memDone)
        begin
            logAddr[nAcc] <= memVaddr;
            logData[nAcc] <= memWdata;
            logWrite[nAcc] <= memWrite;
            nAcc <= nAcc + 5'h1;
        end
    end
endmodule
`default_nettype wire

// >>> stack_frame_save_restore_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none
module stack_frame_save_restore_seq_bench
    import stack_frame_pkg::*;
;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, instrValid, instrExtended, instrReady, instrDone;
    logic gprWrEn, xlatExc, memReq, memWrite, memDone, memBusError, excValid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instrWord, rd;
    logic [63:0] stackPointer, gprRdData, gprWrData, xlatVaddr, memVaddr, memWdata, memRdata;
    logic [4:0] gprRdAddr, gprWrAddr, faultAt;
    logic [35:0] xlatPaddr;
    logic [2:0] xlatCacheAttr, xlatExcCode, excCode, code;
    logic [3:0] latency;
    logic err;
    logic [4:0] wrA [$];
    logic [63:0] wrD [$];
    int nFail, nTests, cycles, base;
    // upper half set so a store that leaks it is seen
    assign gprRdData = {32'hffff_ffff, 27'h0, gprRdAddr};
    stack_frame_save_restore_seq uut (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instrValid(instrValid), .instrExtended(instrExtended), .instrWord(instrWord),
        .instrReady(instrReady), .instrDone(instrDone), .stackPointer(stackPointer), .gprRdAddr(gprRdAddr),
        .gprRdData(gprRdData), .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData),
        .xlatVaddr(xlatVaddr), .xlatStore(), .xlatPaddr(xlatPaddr), .xlatCacheAttr(xlatCacheAttr),
        .xlatExc(xlatExc), .xlatExcCode(xlatExcCode), .memReq(memReq), .memWrite(memWrite),
        .memCacheAttr(), .memPaddr(), .memVaddr(memVaddr), .memWdata(memWdata), .memDone(memDone),
        .memBusError(memBusError), .memRdata(memRdata), .excValid(excValid), .excCode(excCode), .excVaddr());
    mem_partner partner (.clock(clock), .rst_n(rst_n), .latency(latency), .faultAt(faultAt),
        .xlatVaddr(xlatVaddr), .xlatPaddr(xlatPaddr), .xlatCacheAttr(xlatCacheAttr), .xlatExc(xlatExc),
        .xlatExcCode(xlatExcCode), .memReq(memReq), .memWrite(memWrite), .memVaddr(memVaddr),
        .memWdata(memWdata), .memDone(memDone), .memBusError(memBusError), .memRdata(memRdata));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task check(input logic [63:0] got, input logic [63:0] exp);
        nTests++;
        if (got !== exp)
        begin
            nFail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop();
        if (nFail == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task run(input logic [31:0] w, input logic ext, input logic [63:0] sp);
        wrA.delete();
        wrD.delete();
        base = partner.nAcc;
        @(posedge clock);
        instrWord <= w;
        instrExtended <= ext;
        stackPointer <= sp;
        instrValid <= 1'b1;
        do @(posedge clock); while (instrReady !== 1'b1);
        instrValid <= 1'b0;
        code = EXC_NONE;
        for (int k = 0; k < 400; k++)
        begin
            @(posedge clock);
            if (excValid === 1'b1)
                code = excCode;
            if (excValid === 1'b1 || instrDone === 1'b1)
                break;
        end
        repeat (3) @(posedge clock);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task t_decode();
        logic [2:0] stExp [15] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 4, 0, 1, 0};
        logic [2:0] argExp [15] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 0, 3, 3, 4};
        // the reserved code is left out on purpose
        for (int c = 0; c < 15; c++)
        begin
            @(posedge clock);
            instrExtended <= 1'b1;
            instrWord <= {12'h0, 4'(c), 16'h0};
            @(posedge clock);
            check(uut.staticCount, stExp[c]);
            check(uut.argCount, argExp[c]);
        end
    endtask
    task t_save(input logic [4:0] fault, input logic big);
        // fault counts from this instruction's first access; all ones means none
        faultAt <= fault == 5'h1f ? fault : 5'(partner.nAcc) + fault;
        if (big)
            apb(CTRL_OFFSET, 1'b1, 32'h5);
        run({16'h0, MAJOR_GROUP_EIGHT, SAVE_RESTORE_FUNC, 4'hf, 4'h0}, 1'b0, 64'h1000);
        if (fault == 5'h2)
        begin
            check(code, EXC_TLB_INVALID);
            check(wrA.size(), 0);
            faultAt <= 5'h1f;
            return;
        end
        check(code, EXC_NONE);
        for (int i = 0; i < 3; i++)
        begin
            check(partner.logAddr[base + i], 64'h1000 - 4 * (i + 1));
            check(partner.logWrite[base + i], 1'b1);
        end
        check(partner.logData[base], big ? 64'h1f : {27'h0, GPR_LINK, 32'h0});
        check(partner.logData[base + 1], big ? {27'h0, 5'h11, 32'h0} : {32'h0, 27'h0, 5'h11});
        check(wrA.size(), 1);
        check(wrD[0], 64'hf80);
    endtask
    task t_restore();
        logic [4:0] regs [14] = '{31, 30, 23, 22, 21, 20, 19, 18, 17, 16, 7, 6, 5, 4};
        latency <= 4'h3;
        run({PREFIX_WIDE_IMMEDIATE, 3'h7, 4'h1, 4'hb, MAJOR_GROUP_EIGHT, SAVE_RESTORE_FUNC, 4'h7, 4'h2}, 1'b1,
            64'h1000);
        check(wrA.size(), 15);
        for (int i = 0; i < 14; i++)
        begin
            check(wrA[i], regs[i]);
            check(partner.logAddr[base + i], 64'h108c - 4 * i);
        end
        check(wrD[0], 64'hffff_ffff_8765_4321);
        check(wrD[1], 64'h1234_5678);
        check(wrA[14], GPR_SP);
        check(wrD[14], 64'h1090);
        latency <= 4'h0;
    endtask
    task t_misaligned();
        run({16'h0, MAJOR_GROUP_EIGHT, SAVE_RESTORE_FUNC, 4'hc, 4'h1}, 1'b0, 64'h1002);
        check(code, EXC_ADDR_ERROR);
        check(partner.nAcc - base, 0);
        run({PREFIX_WIDE_IMMEDIATE, 3'h1, 8'h0, MAJOR_GROUP_EIGHT, SAVE_RESTORE_FUNC, 8'h1}, 1'b1, 64'h1001);
        check(code, EXC_ADDR_ERROR);
        check(wrA.size(), 0);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (gprWrEn === 1'b1)
        begin
            wrA.push_back(gprWrAddr);
            wrD.push_back(gprWrData);
        end
        if (cycles == 5000)
        begin
            nFail++;
            report_and_stop();
        end
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, instrValid, instrExtended} = '0;
        {paddr, pwdata, instrWord, stackPointer, latency} = '0;
        faultAt = 5'h1f;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        apb(CTRL_OFFSET, 1'b0, 32'h0);
        check(rd, {29'h0, CTRL_RESET});
        apb(12'h010, 1'b0, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        t_decode();
        t_save(5'h1f, 1'b0);
        t_restore();
        t_save(5'h2, 1'b0);
        t_save(5'h1f, 1'b1);
        t_misaligned();
        apb(COUNT_OFFSET, 1'b0, 32'h0);
        check(rd, 32'h3);
        report_and_stop();
    end
endmodule
`default_nettype wire
